// *** two_wire_register_slave.sv ***
// two-wire serial slave giving an external master access to 16-bit registers
// assumes register file outside; read data is combinational on reg_rd_addr
`timescale 1ns/1ps
// Overview of operation
// - data line only pulled low or released
// - both lines high means bus idle
// - data falling while clock high is start
// - data rising while clock high is stop
// - one bit per pulse, change while low
// - eight-bit units each followed by acknowledge
// - first byte: address plus direction, 0xba/0xbb
// - acknowledge own address byte
// - transmitter releases, receiver pulls low on ack
// - line left high means no-acknowledge
// - write: register address byte loads pointer
// - two data bytes per register, each acknowledged
// - register updated only after both bytes
// - pointer increments after each full write
// - device shifts bytes out, master acknowledges
// - pointer increments after every 16 bits read
// - no-acknowledge ends read, line released
module two_wire_register_slave #(
   parameter int PTR_W  = 8,
   parameter int DATA_W = 16
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // serial pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // register read port
   output logic [PTR_W-1:0]       reg_rd_addr,
   input  wire logic [DATA_W-1:0] reg_rd_data,
   // register write port
   output logic                   reg_wr_en,
   output logic [PTR_W-1:0]       reg_wr_addr,
   output logic [DATA_W-1:0]      reg_wr_data,
   // status
   output logic                   bus_busy
);

   if (DATA_W != 16 || PTR_W != 8) begin : g_chk
      $error("two_wire_register_slave supports 8-bit pointer and 16-bit data");
   end

   pin_event_if ev ();

   two_wire_slave_pkg::slave_state_e state_reg;
   logic [3:0]        bit_cnt_reg;
   logic [7:0]        rx_reg;
   logic [7:0]        tx_reg;
   logic [7:0]        tx_next;
   logic [7:0]        hold_reg;
   logic [DATA_W-1:0] word_reg;
   logic [PTR_W-1:0]  ptr_reg;
   logic              half_reg;
   logic              rd_dir_reg;
   logic              acked_reg;
   logic              sda_oe_reg;
   logic              wr_en_reg;
   logic [PTR_W-1:0]  wr_addr_reg;
   logic [DATA_W-1:0] wr_data_reg;
   logic              busy_reg;
   logic              byte_done;
   logic              addr_match;
   logic              rx_state;
   logic              ack_state;
   logic              commit;
   logic              rd_load_hi;
   logic              rd_load_lo;

   // byte boundary seen in a given state
   function automatic logic byte_end(input logic                             done,
                                     input two_wire_slave_pkg::slave_state_e cur,
                                     input two_wire_slave_pkg::slave_state_e st);
      return done && (cur == st);
   endfunction

   pin_event_filter #(
      .STAGES (two_wire_slave_pkg::SYNC_STAGES)
   ) u_filter (
      .clock   (clock),
      .sys_rst (sys_rst),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .ev      (ev)
   );

   // decoded conditions
   always_comb begin
      byte_done  = ev.scl_fall && (bit_cnt_reg == two_wire_slave_pkg::BYTE_BITS);
      addr_match = (rx_reg == two_wire_slave_pkg::ADDR_WR_BYTE) ||
                   (rx_reg == two_wire_slave_pkg::ADDR_RD_BYTE);
      rx_state   = (state_reg == two_wire_slave_pkg::ST_ADDR) ||
                   (state_reg == two_wire_slave_pkg::ST_PTR) ||
                   (state_reg == two_wire_slave_pkg::ST_WDATA);
      ack_state  = (state_reg == two_wire_slave_pkg::ST_ADDR_ACK) ||
                   (state_reg == two_wire_slave_pkg::ST_PTR_ACK) ||
                   (state_reg == two_wire_slave_pkg::ST_WDATA_ACK) ||
                   (state_reg == two_wire_slave_pkg::ST_RD_ACK);
      commit     = byte_done && (state_reg == two_wire_slave_pkg::ST_WDATA) && half_reg;
      // read begins after read address ack
      rd_load_hi = ev.scl_fall && (state_reg == two_wire_slave_pkg::ST_ADDR_ACK) && rd_dir_reg;
      rd_load_lo = 1'b0;
      if (ev.scl_fall && (state_reg == two_wire_slave_pkg::ST_RD_ACK) && acked_reg) begin
         // after a lower half fetch the next word
         rd_load_lo = half_reg;
         rd_load_hi = !half_reg;
      end
   end

   // protocol state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= two_wire_slave_pkg::ST_IDLE;
      end else if (ev.stop) begin
         state_reg <= two_wire_slave_pkg::ST_IDLE;
      end else if (ev.start) begin
         state_reg <= two_wire_slave_pkg::ST_ADDR;
      end else begin
         case (state_reg)
            two_wire_slave_pkg::ST_ADDR: begin
               if (byte_done) begin
                  state_reg <= addr_match ? two_wire_slave_pkg::ST_ADDR_ACK : two_wire_slave_pkg::ST_IGNORE;
               end
            end
            two_wire_slave_pkg::ST_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  state_reg <= rd_dir_reg ? two_wire_slave_pkg::ST_RDATA : two_wire_slave_pkg::ST_PTR;
               end
            end
            two_wire_slave_pkg::ST_PTR: begin
               if (byte_done) begin
                  state_reg <= two_wire_slave_pkg::ST_PTR_ACK;
               end
            end
            two_wire_slave_pkg::ST_PTR_ACK: begin
               if (ev.scl_fall) begin
                  state_reg <= two_wire_slave_pkg::ST_WDATA;
               end
            end
            two_wire_slave_pkg::ST_WDATA: begin
               if (byte_done) begin
                  state_reg <= two_wire_slave_pkg::ST_WDATA_ACK;
               end
            end
            two_wire_slave_pkg::ST_WDATA_ACK: begin
               if (ev.scl_fall) begin
                  state_reg <= two_wire_slave_pkg::ST_WDATA;
               end
            end
            two_wire_slave_pkg::ST_RDATA: begin
               if (byte_done) begin
                  state_reg <= two_wire_slave_pkg::ST_RD_ACK;
               end
            end
            two_wire_slave_pkg::ST_RD_ACK: begin
               if (ev.scl_fall) begin
                  state_reg <= acked_reg ? two_wire_slave_pkg::ST_RDATA : two_wire_slave_pkg::ST_IGNORE;
               end
            end
            two_wire_slave_pkg::ST_IDLE: begin
               state_reg <= two_wire_slave_pkg::ST_IDLE;
            end
            // wait here for the next start
            two_wire_slave_pkg::ST_IGNORE: begin
               state_reg <= two_wire_slave_pkg::ST_IGNORE;
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // bit counting and receive shifting
   always_ff @(posedge clock) begin
      if (sys_rst || ev.start || ev.stop) begin
         bit_cnt_reg <= two_wire_slave_pkg::BIT_CNT_RST;
         rx_reg      <= 8'h00;
      end else if (byte_done || (ev.scl_fall && ack_state)) begin
         bit_cnt_reg <= two_wire_slave_pkg::BIT_CNT_RST;
      end else if (ev.scl_rise && (rx_state || state_reg == two_wire_slave_pkg::ST_RDATA)) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (rx_state) begin
            rx_reg <= {rx_reg[6:0], ev.sda};
         end
      end
   end

   // direction, byte half and master acknowledge
   always_ff @(posedge clock) begin
      if (sys_rst || ev.start || ev.stop) begin
         rd_dir_reg <= 1'b0;
         half_reg   <= 1'b0;
         acked_reg  <= 1'b0;
      end else begin
         if (byte_end(byte_done, state_reg, two_wire_slave_pkg::ST_ADDR)) begin
            rd_dir_reg <= rx_reg[0];
         end
         if (ev.scl_fall && (state_reg == two_wire_slave_pkg::ST_ADDR_ACK ||
                             state_reg == two_wire_slave_pkg::ST_PTR_ACK)) begin
            half_reg <= 1'b0;
         end else if (byte_done && (state_reg == two_wire_slave_pkg::ST_WDATA ||
                                    state_reg == two_wire_slave_pkg::ST_RDATA)) begin
            half_reg <= !half_reg;
         end
         // high on ack slot is no-acknowledge
         if (ev.scl_rise && state_reg == two_wire_slave_pkg::ST_RD_ACK) begin
            acked_reg <= !ev.sda;
         end
      end
   end

   // next transmit byte
   always_comb begin
      tx_next = {tx_reg[6:0], 1'b0};
      if (rd_load_hi) begin
         tx_next = reg_rd_data[15:8];
      end else if (rd_load_lo) begin
         tx_next = word_reg[7:0];
      end
   end

   // data line drive; oe high pulls the line low
   always_ff @(posedge clock) begin
      if (sys_rst || ev.start || ev.stop) begin
         sda_oe_reg <= 1'b0;
         tx_reg     <= 8'h00;
      end else if (byte_done && rx_state) begin
         sda_oe_reg <= (state_reg != two_wire_slave_pkg::ST_ADDR) || addr_match;
      end else if (rd_load_hi || rd_load_lo) begin
         tx_reg     <= tx_next;
         sda_oe_reg <= !tx_next[7];
      end else if (ev.scl_fall && state_reg == two_wire_slave_pkg::ST_RDATA) begin
         if (byte_done) begin
            sda_oe_reg <= 1'b0;
         end else begin
            tx_reg     <= tx_next;
            sda_oe_reg <= !tx_next[7];
         end
      end else if (ev.scl_fall && ack_state) begin
         sda_oe_reg <= 1'b0;
      end
   end

   // read word capture
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         word_reg <= '0;
      end else if (rd_load_hi) begin
         word_reg <= reg_rd_data;
      end
   end

   // register pointer
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ptr_reg <= two_wire_slave_pkg::PTR_RST;
      end else if (byte_end(byte_done, state_reg, two_wire_slave_pkg::ST_PTR)) begin
         ptr_reg <= rx_reg;
      end else if (commit) begin
         ptr_reg <= ptr_reg + 8'h01;
      end else if (byte_end(byte_done, state_reg, two_wire_slave_pkg::ST_RDATA) && half_reg) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // write port
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hold_reg    <= 8'h00;
         wr_en_reg   <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end else begin
         wr_en_reg <= 1'b0;
         if (byte_end(byte_done, state_reg, two_wire_slave_pkg::ST_WDATA) && !half_reg) begin
            hold_reg <= rx_reg;
         end
         if (commit) begin
            wr_en_reg   <= 1'b1;
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= {hold_reg, rx_reg};
         end
      end
   end

   // idle when no frame is open
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         busy_reg <= 1'b0;
      end else if (ev.stop) begin
         busy_reg <= 1'b0;
      end else if (ev.start) begin
         busy_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      sda_out <= 1'b0;
   end

   assign sda_oe      = sda_oe_reg;
   assign reg_rd_addr = ptr_reg;
   assign reg_wr_en   = wr_en_reg;
   assign reg_wr_addr = wr_addr_reg;
   assign reg_wr_data = wr_data_reg;
   assign bus_busy    = busy_reg;

endmodule

// *** two_wire_slave_pkg.sv ***
// constants, state encoding for the two-wire register slave
// assumes a single system clock domain; pins are synchronised inside
package two_wire_slave_pkg;

   // address bytes answered, direction in bit 0
   localparam logic [7:0] ADDR_WR_BYTE = 8'hba;
   localparam logic [7:0] ADDR_RD_BYTE = 8'hbb;

   // bits per transfer unit before the acknowledge slot
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   // pin synchroniser depth
   localparam int         SYNC_STAGES  = 3;

   // reset values
   localparam logic       LINE_IDLE    = 1'b1;
   localparam logic [3:0] BIT_CNT_RST  = 4'h0;
   localparam logic [7:0] PTR_RST      = 8'h00;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_PTR       = 4'b0011,
      ST_PTR_ACK   = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RD_ACK    = 4'b1000,
      ST_IGNORE    = 4'b1001
   } slave_state_e;

endpackage

// *** pin_event_if.sv ***
// filtered line levels and bus events between pin filter and slave fsm
// assumes all signals are on the system clock
`timescale 1ns/1ps
interface pin_event_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;

   modport filt (
      output scl,
      output sda,
      output scl_rise,
      output scl_fall,
      output start,
      output stop
   );

   modport fsm (
      input  scl,
      input  sda,
      input  scl_rise,
      input  scl_fall,
      input  start,
      input  stop
   );
endinterface

// *** pin_event_filter.sv ***
// three-stage synchroniser and edge/condition detector for clock and data pins
// assumes pins are asynchronous to clock; idle lines are high
`timescale 1ns/1ps
module pin_event_filter #(
   parameter int STAGES = two_wire_slave_pkg::SYNC_STAGES
) (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  sys_rst,
   // raw pins
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   // events
   pin_event_if.filt  ev
);

   if (STAGES != 3) begin : g_chk
      $error("pin_event_filter supports exactly three stages");
   end

   logic [1:0] pin_raw;
   logic [1:0] s1_reg;
   logic [1:0] s2_reg;
   logic [1:0] s3_reg;
   logic [1:0] lvl_reg;
   logic [1:0] lvl_next;

   assign pin_raw = {scl_in, sda_in};

   // per line: change accepted once stages two and three agree
   for (genvar i = 0; i < 2; i++) begin : g_line
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            s1_reg[i]  <= two_wire_slave_pkg::LINE_IDLE;
            s2_reg[i]  <= two_wire_slave_pkg::LINE_IDLE;
            s3_reg[i]  <= two_wire_slave_pkg::LINE_IDLE;
            lvl_reg[i] <= two_wire_slave_pkg::LINE_IDLE;
         end else begin
            s1_reg[i]  <= pin_raw[i];
            s2_reg[i]  <= s1_reg[i];
            s3_reg[i]  <= s2_reg[i];
            lvl_reg[i] <= lvl_next[i];
         end
      end
      assign lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
   end

   assign ev.scl      = lvl_next[1];
   assign ev.sda      = lvl_next[0];
   assign ev.scl_rise = lvl_next[1] & ~lvl_reg[1];
   assign ev.scl_fall = ~lvl_next[1] & lvl_reg[1];
   // start: data falls while clock stays high
   assign ev.start    = lvl_reg[1] & lvl_next[1] & lvl_reg[0] & ~lvl_next[0];
   // stop: data rises while clock stays high
   assign ev.stop     = lvl_reg[1] & lvl_next[1] & ~lvl_reg[0] & lvl_next[0];

endmodule

// *** two_wire_slave_properties.sv ***
// concurrent checks on the ports of the two-wire register slave
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module two_wire_slave_properties #(
   parameter int PTR_W  = 8,
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic              clock,
   input wire logic              sys_rst,
   // serial pins
   input wire logic              scl_in,
   input wire logic              sda_in,
   input wire logic              sda_out,
   input wire logic              sda_oe,
   // register ports
   input wire logic [PTR_W-1:0]  reg_rd_addr,
   input wire logic [DATA_W-1:0] reg_rd_data,
   input wire logic              reg_wr_en,
   input wire logic [PTR_W-1:0]  reg_wr_addr,
   input wire logic [DATA_W-1:0] reg_wr_data,
   // status
   input wire logic              bus_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_pull_low_only: assert property (sda_out == 1'b0)
      else $error("data drive value not low");
   a_start_seen: assert property ($fell(sda_in) && scl_in |-> ##[2:6] bus_busy)
      else $error("start not followed by busy");
   a_stop_seen: assert property ($rose(sda_in) && scl_in |-> ##[2:6] !bus_busy)
      else $error("stop not followed by idle");
   a_idle_released: assert property (!bus_busy |-> !sda_oe)
      else $error("data driven while bus idle");
   a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   a_write_pulse_once: assert property (reg_wr_en |=> !reg_wr_en)
      else $error("write strobe longer than one cycle");
   a_write_in_frame: assert property (reg_wr_en |-> bus_busy && !scl_in)
      else $error("write outside a frame or clock phase");
   a_ptr_after_write: assert property (reg_wr_en |-> reg_rd_addr == PTR_W'(reg_wr_addr + 1'b1))
      else $error("pointer not one past written register");
   a_wr_fields_hold: assert property (!reg_wr_en && !$past(sys_rst) |->
      $stable(reg_wr_addr) && $stable(reg_wr_data))
      else $error("write address or data moved without strobe");
endmodule

bind two_wire_register_slave two_wire_slave_properties #(.PTR_W(PTR_W), .DATA_W(DATA_W)) u_props (
   .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
   .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .bus_busy(bus_busy));

// *** two_wire_master_model.sv ***
// behavioural bus master for the two-wire link, 800 ns bit period
// assumes an external pull-up resolves the data wire outside
`timescale 1ns/1ps
module two_wire_master_model (
   // clock
   input  wire logic clock,
   // link pins
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // master clocks, change low, sample high
   task automatic bit_io(input logic b, output logic s);
      @(posedge clock);
      sda_low <= ~b;
      repeat (5) @(posedge clock);
      scl <= 1'b1;
      repeat (2) @(posedge clock);
      s = sda_wire;
      scl <= 1'b0;
   endtask

   task automatic start_cond;
      @(posedge clock);
      sda_low <= 1'b0;
      repeat (5) @(posedge clock);
      scl <= 1'b1;
      repeat (2) @(posedge clock);
      sda_low <= 1'b1;
      repeat (2) @(posedge clock);
      scl <= 1'b0;
   endtask

   task automatic stop_cond;
      @(posedge clock);
      sda_low <= 1'b1;
      repeat (5) @(posedge clock);
      scl <= 1'b1;
      repeat (2) @(posedge clock);
      sda_low <= 1'b0;
      repeat (6) @(posedge clock);
   endtask

   task automatic write_byte(input logic [7:0] d, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, nak);
   endtask

   // master acks or ends with no-ack
   task automatic read_byte(input logic nak, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(nak, s);
   endtask
endmodule

// *** two_wire_register_slave_bench.sv ***
// self-checking bench for the two-wire register slave
// assumes register file modelled here, master model drives the link
`timescale 1ns/1ps
module two_wire_register_slave_bench;
   logic        clock;
   logic        sys_rst;
   logic        scl;
   logic        m_low;
   logic        sda_wire;
   logic        sda_out;
   logic        sda_oe;
   logic        reg_wr_en;
   logic        bus_busy;
   logic [7:0]  reg_rd_addr;
   logic [7:0]  reg_wr_addr;
   logic [15:0] reg_rd_data;
   logic [15:0] reg_wr_data;
   logic [15:0] regs [256];
   int          n_fail;
   int          n_tests;
   int          n_writes;

   // pull-up wire resolution
   assign sda_wire = ~(m_low | (sda_oe & ~sda_out));
   assign reg_rd_data = regs[reg_rd_addr];

   two_wire_register_slave u_two_wire_register_slave (
      .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .bus_busy(bus_busy));

   two_wire_master_model u_two_wire_master_model (.clock(clock), .scl(scl), .sda_low(m_low), .sda_wire(sda_wire));

   always #50 clock = ~clock;

   always @(posedge clock) begin
      if (reg_wr_en === 1'b1) begin
         regs[reg_wr_addr] <= reg_wr_data;
         n_writes <= n_writes + 1;
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic send(input logic [7:0] d, input logic exp_nak);
      logic nak;
      u_two_wire_master_model.write_byte(d, nak);
      check("ack slot", {15'h0000, nak}, {15'h0000, exp_nak});
   endtask

   task automatic t_reset_vals;
      check("sda_oe", 16'(sda_oe), 16'h0000);
      check("bus_busy", 16'(bus_busy), 16'h0000);
      check("reg_rd_addr", 16'(reg_rd_addr), 16'h0000);
      check("reg_wr_en", 16'(reg_wr_en), 16'h0000);
   endtask

   task automatic t_write_one;
      int w0;
      w0 = n_writes;
      u_two_wire_master_model.start_cond();
      send(two_wire_slave_pkg::ADDR_WR_BYTE, 1'b0);
      send(8'h09, 1'b0);
      send(8'h02, 1'b0);
      check("busy in frame", 16'(bus_busy), 16'h0001);
      check("writes after upper", 16'(n_writes - w0), 16'h0000);
      send(8'h84, 1'b0);
      u_two_wire_master_model.stop_cond();
      check("reg 09", regs[8'h09], 16'h0284);
      check("writes", 16'(n_writes - w0), 16'h0001);
      check("busy after stop", 16'(bus_busy), 16'h0000);
      check("pointer", 16'(reg_rd_addr), 16'h000a);
   endtask

   task automatic t_burst_partial;
      int w0;
      w0 = n_writes;
      u_two_wire_master_model.start_cond();
      send(two_wire_slave_pkg::ADDR_WR_BYTE, 1'b0);
      send(8'h20, 1'b0);
      send(8'h12, 1'b0);
      send(8'h34, 1'b0);
      send(8'h56, 1'b0);
      send(8'h78, 1'b0);
      send(8'haa, 1'b0);
      u_two_wire_master_model.stop_cond();
      check("reg 20", regs[8'h20], 16'h1234);
      check("reg 21", regs[8'h21], 16'h5678);
      check("reg 22 untouched", regs[8'h22], 16'h5a22);
      check("burst writes", 16'(n_writes - w0), 16'h0002);
   endtask

   task automatic t_read;
      logic [7:0] b0, b1, b2, b3;
      u_two_wire_master_model.start_cond();
      send(two_wire_slave_pkg::ADDR_WR_BYTE, 1'b0);
      send(8'h20, 1'b0);
      u_two_wire_master_model.start_cond();
      send(two_wire_slave_pkg::ADDR_RD_BYTE, 1'b0);
      u_two_wire_master_model.read_byte(1'b0, b0);
      u_two_wire_master_model.read_byte(1'b0, b1);
      u_two_wire_master_model.read_byte(1'b0, b2);
      u_two_wire_master_model.read_byte(1'b1, b3);
      repeat (8) @(posedge clock);
      check("oe after no-ack", 16'(sda_oe), 16'h0000);
      check("wire after no-ack", 16'(sda_wire), 16'h0001);
      u_two_wire_master_model.stop_cond();
      check("read word 0", {b0, b1}, 16'h1234);
      check("read word 1", {b2, b3}, 16'h5678);
      check("pointer after read", 16'(reg_rd_addr), 16'h0022);
   endtask

   task automatic t_foreign;
      int w0;
      w0 = n_writes;
      u_two_wire_master_model.start_cond();
      send(8'hbc, 1'b1);
      send(8'h09, 1'b1);
      send(8'hff, 1'b1);
      send(8'hff, 1'b1);
      u_two_wire_master_model.stop_cond();
      check("foreign writes", 16'(n_writes - w0), 16'h0000);
      check("foreign pointer", 16'(reg_rd_addr), 16'h0022);
   endtask

   initial begin
      #1_000_000;
      n_fail++;
      summarize();
   end

   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      n_fail = 0;
      n_tests = 0;
      n_writes = 0;
      for (int i = 0; i < 256; i++) begin
         regs[i] = {8'h5a, 8'(i)};
      end
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      #37;
      t_reset_vals();
      t_write_one();
      t_burst_partial();
      t_read();
      t_foreign();
      summarize();
   end
endmodule
